// ==== logic/efs_fault_supervisor.sv ====
// Fault supervisor of a protection switch: qualifies faults, latches them,
// runs retry and chain notification, and drives the flag and good pins.
// Assumes comparator inputs are asynchronous and a pull-up on each pin.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Fault flag pin is open drain, low on fault except a fast trip alone on a secondary.
// - Standalone faults other than drain-source latch, then retry or stay off.
// - Secondary pulses sync line low on fault.
// - Unanswered secondary notice forces chain off, latched.
// - Failsafe clears only by supply or shutdown level.
// - Supply loss or shutdown level clears latch.
// - Same clearing resets the retry timer.
// - Dropping only below UVLO keeps latch.
// - Monitor short with backup overcurrent trips after 45us.
// - Gate-source health fault trips after 10us.
// - Drain-source fault flags after timeout, no latch.
// - Limit pin open in steady forces sharing loop.
// - Limit pin short in steady disables sharing loop.
// - Limit pin open at startup latches fault.
// - Monitor pin open in steady latches fault.
// - Reference open with backup overcurrent trips after blanking.
// - Reference short at startup or in steady latches fault.
// - Blank pin high with overcurrent trips after delay.
// - External sync low while powered latches fault.
// - Good output high only in full-power steady state, or on a secondary in notice.
// - Secondary keeps good high after trip.
// - Good held low at inrush, debounced both ways.
// - Retry waits for cooling then retry delay.
module efs_fault_supervisor #(
  parameter logic [15:0] BLANK_CYC = 16'(efs_pkg::BLANK_CYC),
  parameter logic [15:0] FAST_TRIP_CYC = 16'(efs_pkg::FAST_TRIP_CYC),
  parameter logic [15:0] STARTUP_TIMEOUT_CYC = 16'(efs_pkg::STARTUP_TIMEOUT_CYC),
  parameter logic [15:0] SPF_DELAY_CYC = 16'(efs_pkg::SPF_DELAY_CYC),
  parameter logic [15:0] GOOD_ASSERT_CYC = 16'(efs_pkg::GOOD_ASSERT_CYC),
  parameter logic [15:0] GOOD_DEASSERT_CYC = 16'(efs_pkg::GOOD_DEASSERT_CYC),
  parameter logic [15:0] RETRY_CYC = 16'(efs_pkg::RETRY_CYC)
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire efs_pkg::efs_cond_type COND_IN,
  input wire logic CHAIN_SWITCH_SYNC_I,
  output logic CHAIN_SWITCH_SYNC_O,
  output logic CHAIN_SWITCH_SYNC_OE,
  output logic FAULT_FLAG_N_O,
  output logic FAULT_FLAG_N_OE,
  output logic POWER_GOOD_OUT_O,
  output logic POWER_GOOD_OUT_OE,
  output logic GATE_ON,
  output logic SLEW_LIMITED_STARTUP,
  output logic SHARE_LOOP_FORCE,
  output logic SHARE_LOOP_DISABLE,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  // ---------------------------------------------------------------
  // Local constants
  // ---------------------------------------------------------------
  localparam int NC = efs_pkg::NC;
  localparam logic [15:0] MSH_CYC = 16'(efs_pkg::MON_SHORT_CYC);
  localparam logic [15:0] GS_CYC = 16'(efs_pkg::GS_FAULT_CYC);
  localparam logic [15:0] NOTIFY_CYC = 16'(efs_pkg::NOTIFY_CYC);
  localparam logic [15:0] ACK_WAIT_CYC = 16'(efs_pkg::ACK_WAIT_CYC);
  localparam logic [15:0] SETTLE_CYC = 16'(efs_pkg::ACK_SETTLE_CYC);
  localparam logic [NC-1:0] DS_ONLY = NC'(1) << efs_pkg::C_DS;
  localparam logic [NC-1:0] FT_ONLY = NC'(1) << efs_pkg::C_FT;
  // Last count value per cause; immediate causes trip on first cycle.
  localparam logic [NC-1:0][15:0] LIM_M1 = {
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    STARTUP_TIMEOUT_CYC - 16'h0001,
    STARTUP_TIMEOUT_CYC - 16'h0001,
    SPF_DELAY_CYC - 16'h0001,
    BLANK_CYC - 16'h0001,
    GS_CYC - 16'h0001,
    MSH_CYC - 16'h0001,
    FAST_TRIP_CYC - 16'h0001,
    BLANK_CYC - 16'h0001
  };
  // Bound for the good-drop check, in cycles.
  localparam int GOOD_DROP_MAX = 27;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  // Everything the block remembers lives in this one record.
  typedef struct packed {
    efs_pkg::efs_state_type state;
    efs_pkg::efs_cond_type cond_s1;
    efs_pkg::efs_cond_type cond_s2;
    logic sync_s1;
    logic sync_s2;
    logic [NC-1:0][15:0] cnt;
    logic [NC-1:0] cause;
    logic latched;
    logic flag_low;
    logic sync_drive;
    logic gate;
    logic good;
    logic [15:0] tmr;
    logic [15:0] good_cnt;
    logic [1:0] ctrl;
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } efs_regs_type;

  localparam efs_regs_type ST_RESET = '0;

  efs_regs_type st_r;
  efs_regs_type st_nxt;

  // ---------------------------------------------------------------
  // Decoded conditions
  // ---------------------------------------------------------------
  efs_pkg::efs_cond_type c;
  logic sec;
  logic retry;
  logic on;
  logic steady;
  logic startup;
  logic clear;
  logic power_ok;
  logic ext_low;
  logic take_fault;
  logic good_want;
  logic [NC-1:0] raw;
  logic [NC-1:0] trip;
  efs_pkg::efs_status_type status_w;

  // Only the second synchroniser stage is ever read.
  assign c = st_r.cond_s2;
  assign sec = st_r.ctrl[efs_pkg::CTRL_SEC_BIT];
  assign retry = st_r.ctrl[efs_pkg::CTRL_RETRY_BIT];
  assign startup = st_r.state == efs_pkg::ST_STARTUP;
  assign steady = st_r.state == efs_pkg::ST_STEADY;
  assign on = startup || steady;
  // Supply loss or shutdown level wipes every fault.
  assign clear = !c.en_sd || !c.supply_ok;
  assign power_ok = c.enable_undervoltage_in && c.supply_ok && !c.vin_uv && !c.vin_ov;
  // Our own drive is never up while on, so a low line is foreign.
  assign ext_low = on && !st_r.sync_s2 && !c.vin_uv && !c.vin_ov;

  // Raw fault conditions, each gated by the phase it belongs to.
  assign raw[efs_pkg::C_CB] = steady && c.oc_cb;
  assign raw[efs_pkg::C_FT] = on && c.short_ckt;
  assign raw[efs_pkg::C_MSH] = steady && c.mon_short && c.oc_bkp;
  assign raw[efs_pkg::C_GS] = on && c.gs_flt;
  assign raw[efs_pkg::C_ROPEN] = steady && c.ref_open && c.oc_bkp;
  assign raw[efs_pkg::C_SPF] = on && c.blank_high && (c.oc_cb || c.oc_bkp);
  assign raw[efs_pkg::C_SU] = startup && !c.gate_full;
  assign raw[efs_pkg::C_DS] = startup && c.ds_flt;
  assign raw[efs_pkg::C_OT] = on && c.over_temp;
  assign raw[efs_pkg::C_LOPEN] = startup && c.lim_open;
  assign raw[efs_pkg::C_MOPEN] = steady && c.mon_open;
  assign raw[efs_pkg::C_RSHORT] = on && c.ref_short;
  // Gate-drain short shows as gate high while the switch is held off.
  assign raw[efs_pkg::C_GD] = (st_r.state == efs_pkg::ST_OFF) && c.gd_flt;
  assign raw[efs_pkg::C_EXT] = ext_low;

  // A cause trips when its counter has seen the full delay.
  for (genvar i = 0; i < NC; i++) begin : g_trip
    assign trip[i] = raw[i] && (st_r.cnt[i] == LIM_M1[i]);
  end

  assign take_fault = (|trip) && !clear && (on || st_r.state == efs_pkg::ST_OFF);

  // Secondary keeps good up while the primary handles a trip.
  assign good_want = (steady && c.gate_full) ||
    (sec && st_r.good &&
    (st_r.state == efs_pkg::ST_NOTIFY || st_r.state == efs_pkg::ST_ACK_WAIT));

  assign status_w = '{
    rsvd: 21'h0,
    share_dis: SHARE_LOOP_DISABLE,
    share_force: SHARE_LOOP_FORCE,
    sync_drive: st_r.sync_drive,
    good: st_r.good,
    gate: st_r.gate,
    flag_low: st_r.flag_low,
    latched: st_r.latched,
    state: st_r.state
  };

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  // One process computes the whole next record.
  always_comb begin
    st_nxt = st_r;
    st_nxt.cond_s1 = COND_IN;
    st_nxt.cond_s2 = st_r.cond_s1;
    st_nxt.sync_s1 = CHAIN_SWITCH_SYNC_I;
    st_nxt.sync_s2 = st_r.sync_s1;

    // Delay counters run while a cause holds and stop at the limit.
    for (int i = 0; i < NC; i++) begin
      if (!raw[i]) begin
        st_nxt.cnt[i] = 16'h0000;
      end else if (!trip[i]) begin
        st_nxt.cnt[i] = st_r.cnt[i] + 16'h0001;
      end
    end

    if (clear) begin
      // Full clear, retry timer included.
      st_nxt.state = efs_pkg::ST_OFF;
      st_nxt.latched = 1'b0;
      st_nxt.flag_low = 1'b0;
      st_nxt.sync_drive = 1'b0;
      st_nxt.cause = '0;
      st_nxt.tmr = 16'h0000;
    end else if (take_fault) begin
      st_nxt.cause = st_r.cause | trip;
      st_nxt.tmr = 16'h0000;
      if (sec) begin
        // Tell the primary by a short low pulse on the line.
        st_nxt.state = efs_pkg::ST_NOTIFY;
        st_nxt.sync_drive = 1'b1;
        st_nxt.flag_low = |(trip & ~FT_ONLY);
      end else if (trip == DS_ONLY) begin
        // Flag without an internal latch.
        st_nxt.state = efs_pkg::ST_HALT;
        st_nxt.flag_low = 1'b1;
      end else begin
        // Latch, pull flag and hold the chain off.
        st_nxt.state = efs_pkg::ST_LATCHED;
        st_nxt.latched = 1'b1;
        st_nxt.flag_low = 1'b1;
        st_nxt.sync_drive = 1'b1;
      end
    end else begin
      case (st_r.state)
        efs_pkg::ST_OFF: begin
          // Start only with a high chain line so all members start together.
          if (power_ok && st_r.sync_s2) begin
            st_nxt.state = efs_pkg::ST_STARTUP;
            st_nxt.flag_low = 1'b0;
          end
        end
        efs_pkg::ST_STARTUP: begin
          if (!power_ok) begin
            st_nxt.state = efs_pkg::ST_OFF;
          end else if (c.gate_full) begin
            st_nxt.state = efs_pkg::ST_STEADY;
          end
        end
        efs_pkg::ST_STEADY: begin
          // Undervoltage and overvoltage shut down without a latch.
          if (!power_ok) begin
            st_nxt.state = efs_pkg::ST_OFF;
          end
        end
        efs_pkg::ST_LATCHED: begin
          // Retry variant waits to cool, then the retry delay.
          // Latch-off variant waits here for a clear; UVLO alone is no clear.
          if (!retry || c.over_temp) begin
            st_nxt.tmr = 16'h0000;
          end else if (st_r.tmr == RETRY_CYC - 16'h0001) begin
            st_nxt.state = efs_pkg::ST_OFF;
            st_nxt.latched = 1'b0;
            st_nxt.flag_low = 1'b0;
            st_nxt.sync_drive = 1'b0;
            st_nxt.tmr = 16'h0000;
          end else begin
            st_nxt.tmr = st_r.tmr + 16'h0001;
          end
        end
        efs_pkg::ST_HALT: begin
          // A non-latched fault leaves once enable drops below UVLO.
          if (!c.enable_undervoltage_in) begin
            st_nxt.state = efs_pkg::ST_OFF;
            st_nxt.flag_low = 1'b0;
          end
        end
        efs_pkg::ST_NOTIFY: begin
          if (st_r.tmr == NOTIFY_CYC - 16'h0001) begin
            st_nxt.state = efs_pkg::ST_ACK_WAIT;
            st_nxt.sync_drive = 1'b0;
            st_nxt.tmr = 16'h0000;
          end else begin
            st_nxt.tmr = st_r.tmr + 16'h0001;
          end
        end
        efs_pkg::ST_ACK_WAIT: begin
          // Skip the synchroniser lag of our own release first.
          st_nxt.tmr = st_r.tmr + 16'h0001;
          if (st_r.tmr >= SETTLE_CYC && !st_r.sync_s2) begin
            st_nxt.state = efs_pkg::ST_OFF;
          end else if (st_r.tmr == ACK_WAIT_CYC - 16'h0001) begin
            // Primary never answered: pull the whole chain down.
            st_nxt.state = efs_pkg::ST_FAILSAFE;
            st_nxt.latched = 1'b1;
            st_nxt.flag_low = 1'b1;
            st_nxt.sync_drive = 1'b1;
          end
        end
        efs_pkg::ST_FAILSAFE: begin
          // Held until supply or shutdown clear.
          st_nxt.state = efs_pkg::ST_FAILSAFE;
        end
        default: begin
          st_nxt.state = efs_pkg::ST_OFF;
        end
      endcase
    end

    st_nxt.gate = (st_nxt.state == efs_pkg::ST_STARTUP) ||
      (st_nxt.state == efs_pkg::ST_STEADY);

    // Good output follows its target after a debounce each way.
    if (good_want == st_r.good) begin
      st_nxt.good_cnt = 16'h0000;
    end else if (st_r.good_cnt ==
        (st_r.good ? GOOD_DEASSERT_CYC : GOOD_ASSERT_CYC) - 16'h0001) begin
      st_nxt.good = good_want;
      st_nxt.good_cnt = 16'h0000;
    end else begin
      st_nxt.good_cnt = st_r.good_cnt + 16'h0001;
    end

    // Register bus: capture address and data in any order.
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      st_nxt.aw_have = 1'b1;
      st_nxt.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      st_nxt.w_have = 1'b1;
      st_nxt.w_data = S_AXI_WDATA;
      st_nxt.w_strb = S_AXI_WSTRB;
    end
    if (st_r.aw_have && st_r.w_have) begin
      // Only the control word is writable.
      st_nxt.aw_have = 1'b0;
      st_nxt.w_have = 1'b0;
      st_nxt.bvalid = 1'b1;
      case (st_r.aw_addr)
        efs_pkg::ADDR_CTRL: begin
          st_nxt.bresp = efs_pkg::RESP_OKAY;
          if (st_r.w_strb[0]) begin
            st_nxt.ctrl = st_r.w_data[1:0];
          end
        end
        efs_pkg::ADDR_STATUS, efs_pkg::ADDR_CAUSE: begin
          st_nxt.bresp = efs_pkg::RESP_SLVERR;
        end
        default: begin
          st_nxt.bresp = efs_pkg::RESP_DECERR;
        end
      endcase
    end else if (st_r.bvalid && S_AXI_BREADY) begin
      st_nxt.bvalid = 1'b0;
    end

    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = efs_pkg::RESP_OKAY;
      case (S_AXI_ARADDR)
        efs_pkg::ADDR_CTRL: st_nxt.rdata = {30'h0, st_r.ctrl};
        efs_pkg::ADDR_STATUS: st_nxt.rdata = status_w;
        efs_pkg::ADDR_CAUSE: st_nxt.rdata = {18'h0, st_r.cause};
        default: begin
          st_nxt.rdata = 32'h0;
          st_nxt.rresp = efs_pkg::RESP_DECERR;
        end
      endcase
    end else if (st_r.rvalid && S_AXI_RREADY) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Open-drain pins only ever pull low.
  assign FAULT_FLAG_N_O = 1'b0;
  assign FAULT_FLAG_N_OE = st_r.flag_low;
  assign POWER_GOOD_OUT_O = 1'b0;
  assign POWER_GOOD_OUT_OE = !st_r.good;
  assign CHAIN_SWITCH_SYNC_O = 1'b0;
  assign CHAIN_SWITCH_SYNC_OE = st_r.sync_drive;
  assign GATE_ON = st_r.gate;
  // Every turn-on runs the slew-limited ramp.
  assign SLEW_LIMITED_STARTUP = startup;
  // Sharing loop overrides carry no fault.
  assign SHARE_LOOP_FORCE = steady && c.lim_open;
  assign SHARE_LOOP_DISABLE = steady && c.lim_short;
  // Address and data wait while a response is pending.
  assign S_AXI_AWREADY = !st_r.aw_have && !st_r.bvalid;
  assign S_AXI_WREADY = !st_r.w_have && !st_r.bvalid;
  assign S_AXI_BVALID = st_r.bvalid;
  assign S_AXI_BRESP = st_r.bresp;
  assign S_AXI_ARREADY = !st_r.rvalid;
  assign S_AXI_RVALID = st_r.rvalid;
  assign S_AXI_RDATA = st_r.rdata;
  assign S_AXI_RRESP = st_r.rresp;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_B);

  chk_latch_flag: assert property (
    (st_r.state == efs_pkg::ST_LATCHED) |-> FAULT_FLAG_N_OE && !GATE_ON)
    else $error("latched fault without flag or with gate on");
  chk_clear_all: assert property (
    clear |=> st_r.state == efs_pkg::ST_OFF && !FAULT_FLAG_N_OE && st_r.tmr == 16'h0)
    else $error("clear did not release fault");
  chk_uvlo_keeps: assert property (
    (st_r.state == efs_pkg::ST_LATCHED && !clear && !retry) |=>
    st_r.state == efs_pkg::ST_LATCHED)
    else $error("latch lost without clear");
  chk_mon_short_wait: assert property (
    $rose(raw[efs_pkg::C_MSH]) |-> !trip[efs_pkg::C_MSH] [*8])
    else $error("monitor short tripped early");
  chk_gs_latch: assert property (
    (take_fault && !sec && trip[efs_pkg::C_GS]) |=>
    st_r.latched && FAULT_FLAG_N_OE)
    else $error("gate-source fault not latched");
  chk_ds_nolatch: assert property (
    (take_fault && !sec && trip == DS_ONLY) |=>
    st_r.state == efs_pkg::ST_HALT && !st_r.latched && FAULT_FLAG_N_OE)
    else $error("drain-source fault handled wrongly");
  chk_share_flag: assert property (
    (steady && !(|trip) && (c.lim_open || c.lim_short)) |=> !FAULT_FLAG_N_OE)
    else $error("sharing override raised flag");
  chk_notify_len: assert property (
    $rose(st_r.state == efs_pkg::ST_NOTIFY) |->
    CHAIN_SWITCH_SYNC_OE ##4 st_r.state != efs_pkg::ST_NOTIFY)
    else $error("notify pulse length wrong");
  chk_failsafe_hold: assert property (
    (st_r.state == efs_pkg::ST_FAILSAFE) |-> CHAIN_SWITCH_SYNC_OE && FAULT_FLAG_N_OE)
    else $error("failsafe not holding chain down");
  chk_ext_latch: assert property (
    (take_fault && !sec && trip[efs_pkg::C_EXT]) |=> st_r.state == efs_pkg::ST_LATCHED)
    else $error("external fault not latched");
  chk_good_drop: assert property (
    (st_r.good && !good_want) |-> ##[1:GOOD_DROP_MAX] (!st_r.good || good_want))
    else $error("good output did not drop in time");

  cov_steady: cover property ($rose(steady));
  cov_good_up: cover property ($rose(st_r.good));
  cov_retry: cover property (st_r.state == efs_pkg::ST_LATCHED ##1
    st_r.state == efs_pkg::ST_OFF);
  cov_failsafe: cover property ($rose(st_r.state == efs_pkg::ST_FAILSAFE));
endmodule
`default_nettype wire

// ==== logic/efs_pkg.sv ====
// Constants and types shared by the fault supervisor.
// Assumes one 25 MHz system clock and a 32-bit AXI4-Lite register bus.
package efs_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int MON_SHORT_NS = 45000;
  localparam int MON_SHORT_CYC = (MON_SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int GS_FAULT_NS = 10000;
  localparam int GS_FAULT_CYC = (GS_FAULT_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLANK_CYC = 1000;
  localparam int FAST_TRIP_CYC = 2;
  localparam int STARTUP_TIMEOUT_CYC = 4000;
  localparam int SPF_DELAY_CYC = 2000;
  localparam int GOOD_ASSERT_CYC = 100;
  localparam int GOOD_DEASSERT_CYC = 25;
  localparam int RETRY_CYC = 50000;
  localparam int NOTIFY_CYC = 4;
  localparam int ACK_WAIT_CYC = 32;
  localparam int ACK_SETTLE_CYC = 3;
  // ---------------------------------------------------------------
  // Fault causes, one bit each
  // ---------------------------------------------------------------
  localparam int NC = 14;
  localparam int C_CB = 0;
  localparam int C_FT = 1;
  localparam int C_MSH = 2;
  localparam int C_GS = 3;
  localparam int C_ROPEN = 4;
  localparam int C_SPF = 5;
  localparam int C_SU = 6;
  localparam int C_DS = 7;
  localparam int C_OT = 8;
  localparam int C_LOPEN = 9;
  localparam int C_MOPEN = 10;
  localparam int C_RSHORT = 11;
  localparam int C_GD = 12;
  localparam int C_EXT = 13;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int AXI_AW = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CAUSE = 8'h08;
  localparam int CTRL_SEC_BIT = 0;
  localparam int CTRL_RETRY_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [3:0] {
    ST_OFF = 4'h0,
    ST_STARTUP = 4'h1,
    ST_STEADY = 4'h2,
    ST_LATCHED = 4'h3,
    ST_HALT = 4'h4,
    ST_NOTIFY = 4'h5,
    ST_ACK_WAIT = 4'h6,
    ST_FAILSAFE = 4'h7
  } efs_state_type;

  // Comparator results from the analog side, all active high.
  typedef struct packed {
    logic enable_undervoltage_in;
    logic en_sd;
    logic supply_ok;
    logic vin_uv;
    logic vin_ov;
    logic over_temp;
    logic oc_cb;
    logic oc_bkp;
    logic short_ckt;
    logic gate_full;
    logic gs_flt;
    logic gd_flt;
    logic ds_flt;
    logic lim_open;
    logic lim_short;
    logic mon_open;
    logic mon_short;
    logic ref_open;
    logic ref_short;
    logic blank_high;
  } efs_cond_type;

  typedef struct packed {
    logic [20:0] rsvd;
    logic share_dis;
    logic share_force;
    logic sync_drive;
    logic gate;
    logic good;
    logic flag_low;
    logic latched;
    efs_state_type state;
  } efs_status_type;
endpackage

// ==== testbench/efs_chain_partner.sv ====
// Model of the primary at the far end of the wired-low chain sync line.
// Assumes a pull-up on the line; ACK_EN makes the primary answer a notice.
`timescale 1ns/100ps
`default_nettype none
module efs_chain_partner (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic SYNC_OE,
  input wire logic ACK_EN,
  input wire logic EXT_PULL,
  output logic SYNC_LINE
);
  logic [3:0] len_r; // Cycles the supervisor has held the line low.
  logic [3:0] gap_r; // Cycles since a short notice ended.
  logic pull_r; // High while this primary answers by pulling low.
  // Only a short low pulse is a notice; a latched hold is never answered,
  // since a reply there would look like a foreign fault at the next start.
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      len_r <= 4'h0;
      gap_r <= 4'h0;
      pull_r <= 1'b0;
    end else begin
      len_r <= SYNC_OE ? len_r + {3'h0, len_r != 4'hf} : 4'h0;
      if (SYNC_OE) begin
        gap_r <= 4'h0;
      end else if (len_r != 4'h0 && len_r < 4'h8) begin
        gap_r <= 4'h1;
      end else if (gap_r != 4'h0) begin
        gap_r <= gap_r + 4'h1;
      end
      pull_r <= ACK_EN && gap_r >= 4'h4 && gap_r < 4'hc;
    end
  end
  // Wired-low: a released line goes back to the pull-up level.
  assign SYNC_LINE = !(SYNC_OE || pull_r || EXT_PULL);
endmodule
`default_nettype wire

// ==== testbench/tb_efs_fault_supervisor.sv ====
// Bench for the fault supervisor: bus tasks, fault scenarios, queued checks.
// Assumes the design package and the chain partner model compile first.
`timescale 1ns/100ps
`default_nettype none
module tb_efs_fault_supervisor;
  logic sys_clk, rst_b = 0, ack_en = 0, ext_pull = 0, sync_line;
  logic [3:0] wstrb = 0; // Lane 0 always set; the other lanes are random.
  efs_pkg::efs_cond_type cond = '0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [4:0] obs; // Share disable, gate, good pull, flag pull, sync pull.
  logic [33:0] exp_q[$]; // Expected response code and read data.
  int err_count = 0, check_count = 0;
  efs_fault_supervisor #(.BLANK_CYC(16'h8), .STARTUP_TIMEOUT_CYC(16'h14), .SPF_DELAY_CYC(16'h8),
    .GOOD_ASSERT_CYC(16'h4), .RETRY_CYC(16'h14)) efs_fault_supervisor_inst (
    .SYS_CLK(sys_clk), .RST_B(rst_b), .COND_IN(cond), .CHAIN_SWITCH_SYNC_I(sync_line),
    .CHAIN_SWITCH_SYNC_O(), .CHAIN_SWITCH_SYNC_OE(obs[0]), .FAULT_FLAG_N_O(),
    .FAULT_FLAG_N_OE(obs[1]), .POWER_GOOD_OUT_O(), .POWER_GOOD_OUT_OE(obs[2]),
    .GATE_ON(obs[3]), .SLEW_LIMITED_STARTUP(), .SHARE_LOOP_FORCE(),
    .SHARE_LOOP_DISABLE(obs[4]), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  efs_chain_partner efs_chain_partner_inst (.SYS_CLK(sys_clk), .RST_B(rst_b),
    .SYNC_OE(obs[0]), .ACK_EN(ack_en), .EXT_PULL(ext_pull), .SYNC_LINE(sync_line));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // One bus transfer; holds every request until its ready is seen.
  task automatic bus(input bit rd, input logic [7:0] a, input logic [1:0] v,
    input logic [33:0] e);
    bit tk;
    tk = 0;
    exp_q.push_back(e);
    @(posedge sys_clk);
    if (rd) begin
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
    end else begin
      awaddr <= a;
      wdata <= {24'($urandom()), 6'h0, v};
      wstrb <= 4'($urandom()) | 4'h1;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
    end
    while (!tk) begin
      @(posedge sys_clk);
      tk = rd ? arready : (awready && wready);
    end
    arvalid <= 0;
    awvalid <= 0;
    wvalid <= 0;
    do @(posedge sys_clk); while (!(rd ? rvalid : bvalid));
    rready <= 0;
    bready <= 0;
  endtask
  // Waits a bounded time for one watched pin to reach a level.
  task automatic await(input int k, input logic v);
    for (int i = 0; i < 300 && obs[k] !== v; i++) @(posedge sys_clk);
    check(34'(obs[k]), 34'(v));
  endtask
  task automatic power_up();
    cond.enable_undervoltage_in <= 1;
    cond.en_sd <= 1;
    cond.supply_ok <= 1;
    cond.gate_full <= 0;
    await(3, 1);
    cond.gate_full <= 1;
    await(2, 0);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Clock, response watcher, watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 0;
    forever #20 sys_clk = ~sys_clk;
  end
  // The oldest note is the answer to the transfer now completing.
  always @(posedge sys_clk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      check(bvalid ? {bresp, 32'h0} : {rresp, rdata}, exp_q.pop_front());
    end
  end
  initial begin
    #1000000;
    err_count++;
    complete_run();
  end
  initial begin
    void'($urandom(2));
    repeat (2) @(posedge sys_clk);
    rst_b <= 1;
    check(34'(obs[1]), 34'h0);
    check(34'(obs[2]), 34'h1);
    bus(0, 8'h00, 2'h0, 34'h0);
    bus(1, 8'h00, 2'h0, 34'h0);
    bus(0, 8'h04, 2'h1, {2'h2, 32'h0});
    bus(1, 8'h0c, 2'h0, {2'h3, 32'h0});
    cond.lim_short <= 1;
    power_up();
    await(4, 1);
    check(34'(obs[1]), 34'h0);
    cond.lim_short <= 0;
    cond.mon_open <= 1;
    await(1, 1);
    check(34'(obs[3]), 34'h0);
    cond.mon_open <= 0;
    cond.enable_undervoltage_in <= 0;
    repeat (8) @(posedge sys_clk);
    check(34'(obs[1]), 34'h1);
    cond.en_sd <= 0;
    await(1, 0);
    bus(0, 8'h00, 2'h2, 34'h0);
    power_up();
    ext_pull <= 1;
    await(1, 1);
    ext_pull <= 0;
    await(1, 0);
    cond.gs_flt <= 1;
    await(1, 1);
    cond.gs_flt <= 0;
    cond.en_sd <= 0;
    await(1, 0);
    bus(0, 8'h00, 2'h1, 34'h0);
    power_up();
    cond.mon_open <= 1;
    await(0, 1);
    await(1, 1);
    repeat (60) @(posedge sys_clk);
    check(34'(obs[0]), 34'h1);
    cond.mon_open <= 0;
    cond.en_sd <= 0;
    await(0, 0);
    ack_en <= 1;
    power_up();
    cond.mon_open <= 1;
    await(0, 1);
    cond.mon_open <= 0;
    repeat (60) @(posedge sys_clk);
    check(34'(obs[1]), 34'h0);
    complete_run();
  end
endmodule
`default_nettype wire
